// ==== design/sgram_ctrl_pkg.sv ====
// Package for the graphics DRAM command controller.
// Assumes one clock domain; the memory samples pins on rising edges.
`default_nettype none
package sgram_ctrl_pkg;
    localparam int DATA_W      = 32;
    localparam int MASK_W      = 4;
    localparam int ADDR_W      = 9;
    localparam int AP_BIT      = 8;
    localparam int READ_MASK_LAT = 2;
    localparam int FIFO_DEPTH  = 8;

    // Command codes on the host port
    typedef enum logic [3:0] {
        CMD_NOP, CMD_ACT, CMD_ACT_MW, CMD_PRE, CMD_PRE_ALL, CMD_WRITE,
        CMD_BWRITE, CMD_READ, CMD_MRS, CMD_SMRS, CMD_STOP, CMD_AREF,
        CMD_SREF, CMD_PDOWN, CMD_SUSPEND, CMD_WAKE
    } cmd_e;

    // Pin pattern: chip select, row, column, write strobes, special sel
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic special_function_select;
    } pins_s;

    // One request from the user side
    typedef struct packed {
        cmd_e              cmd;
        logic              bank_choice;
        logic [ADDR_W-1:0] addr;
        logic              auto_precharge_bit;
        logic [MASK_W-1:0] byte_mask;
        logic [DATA_W-1:0] wdata;
    } req_s;

    localparam int REQ_W = $bits(req_s);

    localparam pins_s PINS_DESEL = 5'h1F;
    localparam pins_s PINS_NOP   = 5'h0E;
endpackage
`default_nettype wire

// ==== design/sgram_host_ctrl.sv ====
// Host-side controller that drives a dual-bank graphics DRAM over pins.
// Assumes the memory shares core_clk_i; read data is resynchronised.
//
// Operation
// RULE1 - Special select joins strobes to pick commands
// RULE2 - Each byte mask governs one data byte
// RULE3 - High write mask stops byte storage
// RULE4 - High read mask hides byte two clocks on
// RULE5 - High mask floats byte, low enables it
// RULE6 - Data lines move on rising clock edges
// RULE7 - Block write data carries column masks
// RULE8 - Commands count only after enable high
// RULE9 - Activate opens row, select enables masking
// RULE10 - Write pattern, select gives block write
// RULE11 - Read pattern with select low
// RULE12 - All strobes low sets mode registers
// RULE13 - Burst stop, no-operation and deselect
// RULE14 - Enable falling while active suspends clock
// RULE15 - Enable fall with idle pattern powers down
// RULE16 - Power down in burst becomes suspend
// RULE17 - Enable low freezes device from next cycle
// RULE18 - Precharge bit high closes both banks
// RULE19 - Precharge pattern accepted in any state
// RULE20 - Refresh pattern: auto or self refresh
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Request FIFO with back-pressure on both sides
module sgram_req_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk_i, // Clock
    input  wire logic             srst_i,     // Sync reset
    input  wire logic             in_valid_i, // Write side valid
    output logic                  in_ready_o, // Not full
    input  wire logic [WIDTH-1:0] in_data_i,  // Write word
    output logic                  out_valid_o,// Not empty
    input  wire logic             out_ready_i,// Read side takes
    output logic      [WIDTH-1:0] out_data_o  // Head word
);
    // Count one bit wider than pointers so full and empty differ
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [PW:0]      count_reg, count_next;
    logic             push, pop;

    // Pointer and count update
    // Modulo wrap keeps a non-power-of-two depth safe
    always_comb begin
        push        = in_valid_i && in_ready_o;
        pop         = out_valid_o && out_ready_i;
        wr_ptr_next = push ? PW'((wr_ptr_reg + 1'b1) % DEPTH) : wr_ptr_reg;
        rd_ptr_next = pop ? PW'((rd_ptr_reg + 1'b1) % DEPTH) : rd_ptr_reg;
        count_next  = count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    // Storage has no reset; only valid words are ever read
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // Flags come from the count alone, so both sides react at once
    assign in_ready_o  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem_reg[rd_ptr_reg];
endmodule

////////////////////////////////////////////////////////////////////////
// Command sequencer and pin driver
module sgram_host_ctrl #(
    parameter int DEPTH = sgram_ctrl_pkg::FIFO_DEPTH
) (
    input  wire logic                           core_clk_i,  // Clock
    input  wire logic                           srst_i,      // Sync reset
    input  wire logic                           req_valid_i, // Request
    output logic                                req_ready_o, // FIFO room
    input  wire sgram_ctrl_pkg::req_s           req_i,       // Request word
    output logic                                busy_o,      // Work queued
    output logic                                rd_valid_o,  // Read word
    output logic [sgram_ctrl_pkg::DATA_W-1:0]   rd_data_o,   // Read data
    output logic                                cke_o,       // Clock enable
    output logic                                cs_n_o,      // Chip select
    output logic                                ras_n_o,     // Row strobe
    output logic                                cas_n_o,     // Column strobe
    output logic                                we_n_o,      // Write strobe
    output logic                                special_function_select_o,
    output logic                                bank_choice_o, // Bank
    output logic [sgram_ctrl_pkg::ADDR_W-1:0]   addr_o,      // Address
    output logic [sgram_ctrl_pkg::MASK_W-1:0]   byte_mask_o, // Byte masks
    output logic [sgram_ctrl_pkg::DATA_W-1:0]   data_lines_o, // Data out
    output logic                                data_lines_oe_n_o, // Low=drive
    input  wire logic [sgram_ctrl_pkg::DATA_W-1:0] data_lines_i // Data in
);
    import sgram_ctrl_pkg::*;

    typedef enum logic [1:0] {ST_RUN, ST_SUSPEND, ST_PDOWN, ST_SREF} mode_e;

    // Pin pattern per command
    // Bit order: select, row, column, write, special function
    function automatic pins_s encode(input cmd_e c);
        case (c)
            CMD_ACT:     encode = 5'b00110;               // RULE9
            CMD_ACT_MW:  encode = 5'b00111;               // RULE9
            CMD_PRE,
            CMD_PRE_ALL: encode = 5'b00100;               // RULE19
            CMD_WRITE:   encode = 5'b01000;               // RULE10
            CMD_BWRITE:  encode = 5'b01001;               // RULE10
            CMD_READ:    encode = 5'b01010;               // RULE11
            CMD_MRS:     encode = 5'b00000;               // RULE12
            CMD_SMRS:    encode = 5'b00001;               // RULE12
            CMD_STOP:    encode = 5'b01100;               // RULE13
            CMD_AREF,
            CMD_SREF:    encode = 5'b00010;               // RULE20
            default:     encode = PINS_NOP;               // RULE13
        endcase
    endfunction

    // Queue decouples user bursts from pin pacing
    logic  fifo_valid, fifo_pop;
    logic [REQ_W-1:0] fifo_data;
    req_s  head;

    sgram_req_fifo #(.WIDTH(REQ_W), .DEPTH(DEPTH)) u_fifo (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .in_valid_i (req_valid_i),
        .in_ready_o (req_ready_o),
        .in_data_i  (req_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o (fifo_data)
    );
    // Queued word read back as a request
    assign head = req_s'(fifo_data);

    // Registered pin state; strobes leave flops so they never glitch
    mode_e mode_reg, mode_next;
    pins_s pins_reg, pins_next;
    logic  cke_reg, cke_next;
    logic  bank_reg, bank_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [MASK_W-1:0] mask_reg, mask_next;
    logic [DATA_W-1:0] wd_reg, wd_next;
    logic  drive_reg, drive_next;
    logic [READ_MASK_LAT-1:0] rd_pipe_reg, rd_pipe_next;
    logic [DATA_W-1:0] sync1_reg, sync2_reg;
    logic [READ_MASK_LAT:0] rd_sync_reg, rd_sync_next;

    // Next pin state: one queued request per cycle
    always_comb begin
        // Defaults: deselect, hold address and masks, release data
        mode_next  = mode_reg;
        pins_next  = PINS_DESEL;
        cke_next   = cke_reg;
        bank_next  = bank_reg;
        addr_next  = addr_reg;
        mask_next  = mask_reg;
        wd_next    = wd_reg;
        drive_next = 1'b0;
        fifo_pop   = 1'b0;
        rd_pipe_next = {rd_pipe_reg[READ_MASK_LAT-2:0], 1'b0};
        if (fifo_valid) begin
            fifo_pop  = 1'b1;
            mask_next = head.byte_mask;                   // RULE2
            case (mode_reg)
                ST_RUN: begin
                    // Commands decoded only since enable was high last cycle
                    cke_next  = 1'b1;                     // RULE8
                    pins_next = encode(head.cmd);         // RULE1
                    bank_next = head.bank_choice;
                    addr_next = head.addr;
                    // Column commands carry their own auto precharge choice
                    if (head.cmd inside {CMD_PRE_ALL, CMD_WRITE, CMD_BWRITE,
                                         CMD_READ}) begin
                        addr_next[AP_BIT] = head.auto_precharge_bit; // RULE18
                    end
                    if (head.cmd == CMD_PRE_ALL) begin
                        addr_next[AP_BIT] = 1'b1;         // RULE18
                    end else if (head.cmd == CMD_PRE ||
                                 head.cmd == CMD_MRS) begin
                        addr_next[AP_BIT] = 1'b0;         // RULE12
                    end
                    if (head.cmd inside {CMD_WRITE, CMD_BWRITE}) begin
                        // Block write carries column/byte masks on data
                        wd_next    = head.wdata;          // RULE7
                        drive_next = 1'b1;                // RULE3
                    end
                    // Read tracking runs on in suspend; keep reads clear of it
                    if (head.cmd == CMD_READ) begin
                        rd_pipe_next[0] = 1'b1;           // RULE4
                    end
                    // Enable drops with the pattern, so the entry is decoded
                    if (head.cmd == CMD_SREF) begin
                        cke_next  = 1'b0;                 // RULE20
                        mode_next = ST_SREF;
                    end else if (head.cmd == CMD_PDOWN) begin
                        // Device treats this as suspend during a burst
                        cke_next  = 1'b0;                 // RULE15
                        pins_next = PINS_NOP;             // RULE16
                        mode_next = ST_PDOWN;
                    end else if (head.cmd == CMD_SUSPEND) begin
                        cke_next  = 1'b0;                 // RULE14
                        mode_next = ST_SUSPEND;
                    end
                end
                ST_SUSPEND: begin
                    // Device frozen; any request wakes it
                    cke_next  = 1'b1;                     // RULE14
                    pins_next = PINS_NOP;                 // RULE17
                    // A wake request is used up; others run next
                    fifo_pop  = (head.cmd == CMD_WAKE);
                    mode_next = ST_RUN;
                end
                ST_PDOWN, ST_SREF: begin
                    // Exit with a deselect pattern, enable rising
                    cke_next  = 1'b1;                     // RULE15
                    pins_next = PINS_DESEL;               // RULE20
                    fifo_pop  = (head.cmd == CMD_WAKE);
                    mode_next = ST_RUN;
                end
                default: mode_next = ST_RUN;
            endcase
        end
    end

    // Pin and mode registers; all pins launch on rising edge
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            mode_reg    <= ST_RUN;
            pins_reg    <= PINS_DESEL;
            cke_reg     <= 1'b1;
            bank_reg    <= 1'b0;
            addr_reg    <= '0;
            mask_reg    <= '1;
            wd_reg      <= '0;
            drive_reg   <= 1'b0;
            rd_pipe_reg <= '0;
        end else begin
            mode_reg    <= mode_next;
            pins_reg    <= pins_next;
            cke_reg     <= cke_next;
            bank_reg    <= bank_next;
            addr_reg    <= addr_next;
            mask_reg    <= mask_next;
            wd_reg      <= wd_next;
            drive_reg   <= drive_next;                    // RULE6
            rd_pipe_reg <= rd_pipe_next;
        end
    end

    // Read capture: two-flop sync, valid delayed to one cycle past the data
    always_comb begin
        rd_sync_next = {rd_sync_reg[READ_MASK_LAT-1:0],
                        rd_pipe_reg[READ_MASK_LAT-1]};
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            // Cleared so no stale word looks like read data
            sync1_reg   <= '0;
            sync2_reg   <= '0;
            rd_sync_reg <= '0;
        end else begin
            sync1_reg   <= data_lines_i;                  // RULE6
            sync2_reg   <= sync1_reg;
            rd_sync_reg <= rd_sync_next;
        end
    end

    // Pins straight from flops; status from queue and read pipe
    assign cs_n_o                    = pins_reg.cs_n;
    assign ras_n_o                   = pins_reg.ras_n;
    assign cas_n_o                   = pins_reg.cas_n;
    assign we_n_o                    = pins_reg.we_n;
    assign special_function_select_o = pins_reg.special_function_select;
    assign cke_o                     = cke_reg;
    assign bank_choice_o             = bank_reg;
    assign addr_o                    = addr_reg;
    assign byte_mask_o               = mask_reg;          // RULE5
    assign data_lines_o              = wd_reg;
    assign data_lines_oe_n_o         = ~drive_reg;
    // Read strobe rises one cycle after the word reaches rd_data_o
    assign rd_valid_o                = rd_sync_reg[READ_MASK_LAT];
    assign rd_data_o                 = sync2_reg;
    assign busy_o                    = fifo_valid;
endmodule
`default_nettype wire

// ==== tb/sgram_host_chk.sv ====
// Pin-level checker for the graphics DRAM host controller.
// Assumes it is bound onto sgram_host_ctrl and sees only its ports.
`default_nettype none
module sgram_host_chk (
    input wire logic                 core_clk_i,  // Clock
    input wire logic                 srst_i,      // Reset
    input wire logic                 req_valid_i, // Request
    input wire logic                 req_ready_o, // Room
    input wire sgram_ctrl_pkg::req_s req_i,       // Word
    input wire logic                 busy_o,      // Queued
    input wire logic                 rd_valid_o,  // Read word
    input wire logic                 cke_o,       // Enable
    input wire logic                 cs_n_o,      // Select
    input wire logic                 ras_n_o,     // Row
    input wire logic                 cas_n_o,     // Column
    input wire logic                 we_n_o,      // Write
    input wire logic                 special_function_select_o, // Special
    input wire logic                 bank_choice_o, // Bank
    input wire logic [8:0]           addr_o,      // Address
    input wire logic [3:0]           byte_mask_o, // Masks
    input wire logic [31:0]          data_lines_o, // Data
    input wire logic                 data_lines_oe_n_o // Low drives
);
    timeunit 1ns;
    timeprecision 1ns;
    import sgram_ctrl_pkg::*;
    wire [3:0] pn = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
    wire       sfs = special_function_select_o;
    wire       take = req_valid_i && req_ready_o;
    logic [1:0] drop_reg;
    logic [1:0] drop_next;
    // A queued enable drop upsets the fixed latency, so skip those
    always_comb drop_next = {drop_reg[0], take &&
        (req_i.cmd inside {CMD_PDOWN, CMD_SUSPEND, CMD_SREF})};
    always_ff @(posedge core_clk_i) drop_reg <= srst_i ? 2'h0 : drop_next;
    wire fresh = take && !busy_o && cke_o && drop_reg == 2'h0;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////////////
    property p_act; fresh && req_i.cmd == CMD_ACT_MW |-> ##2 pn == 4'h3
        && sfs && addr_o == $past(req_i.addr, 2); endproperty
    a_act: assert property (p_act) else $error("bad activate");
    property p_rd; fresh && req_i.cmd == CMD_READ |-> ##2 pn == 4'h5 && !sfs
        && addr_o[AP_BIT] == $past(req_i.auto_precharge_bit, 2); endproperty
    a_rd: assert property (p_rd) else $error("bad read");
    property p_wr; fresh && req_i.cmd inside {CMD_WRITE, CMD_BWRITE} |-> ##2
        pn == 4'h4 && sfs == ($past(req_i.cmd, 2) == CMD_BWRITE)
        && !data_lines_oe_n_o && data_lines_o == $past(req_i.wdata, 2)
        && byte_mask_o == $past(req_i.byte_mask, 2); endproperty
    a_wr: assert property (p_wr) else $error("bad write");
    property p_pall; fresh && req_i.cmd == CMD_PRE_ALL |-> ##2 pn == 4'h2
        && !sfs && addr_o[AP_BIT]; endproperty
    a_pall: assert property (p_pall) else $error("bad close all");
    property p_mrs; fresh && req_i.cmd == CMD_MRS |-> ##2 pn == 4'h0
        && !sfs && !addr_o[AP_BIT]; endproperty
    a_mrs: assert property (p_mrs) else $error("bad mode set");
    property p_aref; fresh && req_i.cmd == CMD_AREF |-> ##2 pn == 4'h1
        && !sfs && cke_o; endproperty
    a_aref: assert property (p_aref) else $error("bad refresh");
    property p_rdv; pn == 4'h5 && cke_o |-> ##4 rd_valid_o; endproperty
    a_rdv: assert property (p_rdv) else $error("read word late");
    property p_wake; $rose(cke_o) |-> cs_n_o || (pn == 4'h7 && !sfs);
    endproperty
    a_wake: assert property (p_wake) else $error("bad wake");
    property p_act0; fresh && req_i.cmd == CMD_ACT |-> ##2 pn == 4'h3
        && !sfs; endproperty
    a_act0: assert property (p_act0) else $error("bad open");
    property p_pre; fresh && req_i.cmd == CMD_PRE |-> ##2 pn == 4'h2 && !sfs
        && !addr_o[AP_BIT] && bank_choice_o == $past(req_i.bank_choice, 2);
    endproperty
    a_pre: assert property (p_pre) else $error("bad close");
    property p_stop; fresh && req_i.cmd == CMD_STOP |-> ##2 pn == 4'h6
        && !sfs; endproperty
    a_stop: assert property (p_stop) else $error("bad stop");
    property p_smrs; fresh && req_i.cmd == CMD_SMRS |-> ##2 pn == 4'h0
        && sfs; endproperty
    a_smrs: assert property (p_smrs) else $error("bad special set");
    property p_sref; fresh && req_i.cmd == CMD_SREF |-> ##2 pn == 4'h1
        && !sfs && !cke_o; endproperty
    a_sref: assert property (p_sref) else $error("bad self refresh");
    property p_pdn; fresh && req_i.cmd == CMD_PDOWN |-> ##2 !cke_o
        && (cs_n_o || (pn == 4'h7 && !sfs)); endproperty
    a_pdn: assert property (p_pdn) else $error("bad power down");
    property p_sus; fresh && req_i.cmd == CMD_SUSPEND |-> ##2 !cke_o;
    endproperty
    a_sus: assert property (p_sus) else $error("bad suspend");
    property p_gate; !$past(cke_o) |-> cs_n_o || pn == 4'h7; endproperty
    a_gate: assert property (p_gate) else $error("frozen command");
endmodule
bind sgram_host_ctrl sgram_host_chk sgram_host_chk_i (.*);
`default_nettype wire

// ==== tb/sgram_dev_model.sv ====
// Behavioural dual-bank graphics DRAM facing the host controller.
// Assumes the bench resolves the shared data wire into data_lines_i.
`default_nettype none
module sgram_dev_model #(
    parameter logic [31:0] COLOR = 32'hC3C3C3C3 // Block write fill
) (
    input  wire logic        core_clk_i,   // Clock
    input  wire logic        cke_o,        // Enable
    input  wire logic        cs_n_o,       // Select
    input  wire logic        ras_n_o,      // Row
    input  wire logic        cas_n_o,      // Column
    input  wire logic        we_n_o,       // Write
    input  wire logic        special_function_select_o, // Special
    input  wire logic        bank_choice_o, // Bank
    input  wire logic [8:0]  addr_o,       // Address
    input  wire logic [3:0]  byte_mask_o,  // Masks
    input  wire logic [31:0] data_lines_i, // Wire level
    output logic      [31:0] dev_dq_o,     // Device drive
    output logic      [7:0]  dev_err_o     // Illegal events
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [512];
    logic [31:0] rd_q = '0;
    logic [3:0]  rm_q = '0;
    logic [3:0]  win_q = '0;
    logic [1:0]  open_q = '0;
    logic        cke_q = 1'b1;
    wire  [3:0]  pn = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
    wire         bk = bank_choice_o;
    wire         sf = special_function_select_o;
    wire  [8:0]  ix = {bk, addr_o[7:0]};
    initial foreach (mem[i]) mem[i] = '0;
    initial dev_err_o = '0;
    // Decode only after a high enable; wake needs an idle pattern
    always @(posedge core_clk_i) begin
        cke_q <= cke_o;
        win_q <= win_q >> 1;
        if (!cke_q && cke_o && !pn[3] && !(pn == 4'h7 && !sf))
            dev_err_o <= dev_err_o + 8'h01;
        if (cke_q) begin
            case (pn)
                4'h3: begin
                    if (open_q[bk]) dev_err_o <= dev_err_o + 8'h01;
                    open_q[bk] <= 1'b1;
                end
                4'h2: if (addr_o[8]) open_q <= 2'h0;
                      else open_q[bk] <= 1'b0;
                4'h4: begin
                    for (int k = 0; k < 8; k++)
                        if (sf && data_lines_i[k])
                            mem[{bk, addr_o[7:3], k[2:0]}] <= COLOR;
                    for (int b = 0; b < 4; b++)
                        if (!sf && !byte_mask_o[b])
                            mem[ix][b*8 +: 8] <= data_lines_i[b*8 +: 8];
                end
                4'h5: begin
                    rd_q <= mem[ix];
                    rm_q <= byte_mask_o;
                    win_q <= 4'hF;
                end
                default: ;
            endcase
        end
    end
    // Floated or masked bytes show the inverse, never a stale match
    always_comb
        for (int b = 0; b < 4; b++)
            dev_dq_o[b*8 +: 8] = (win_q != 4'h0 && !rm_q[b]) ?
                rd_q[b*8 +: 8] : ~rd_q[b*8 +: 8];
endmodule
`default_nettype wire

// ==== tb/sgram_command_decode_tb.sv ====
// Self-checking bench for the graphics DRAM host controller.
// Assumes the package, design, device model and checker are compiled.
`default_nettype none
module sgram_command_decode_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sgram_ctrl_pkg::*;
    localparam logic [31:0] COLOR = 32'hC3C3C3C3;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic req_valid_i = 1'b0;
    req_s req_i = '0;
    logic req_ready_o, busy_o, rd_valid_o, cke_o, cs_n_o, ras_n_o, cas_n_o;
    logic we_n_o, special_function_select_o, bank_choice_o, data_lines_oe_n_o;
    logic [8:0] addr_o;
    logic [3:0] byte_mask_o;
    logic [7:0] dev_err_o;
    logic [31:0] rd_data_o, data_lines_o, dev_dq_o;
    wire  [31:0] data_lines_i;
    int failures = 0;
    int compares = 0;
    // Shared data wire: whichever side is enabled sets the level
    assign data_lines_i = data_lines_oe_n_o ? dev_dq_o : data_lines_o;
    sgram_host_ctrl sgram_host_ctrl_i (.*);
    sgram_dev_model #(.COLOR(COLOR)) sgram_dev_model_i (.*);
    initial forever #5 core_clk_i = ~core_clk_i;
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Held until taken, then one idle edge so commands stand apart
    task automatic send(input cmd_e c, input logic b, input logic [8:0] a,
                        input logic [3:0] m, input logic [31:0] d);
        req_valid_i <= 1'b1;
        req_i <= '{c, b, a, a[AP_BIT], m, d};
        #1;
        while (req_ready_o !== 1'b1) @(posedge core_clk_i) #1;
        @(posedge core_clk_i);
        req_valid_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic cmd(input cmd_e c);
        send(c, 1'b0, 9'h000, 4'h0, 32'h0);
    endtask
    task automatic rd(input logic b, input logic [8:0] a, input logic [3:0] m,
                      input logic [31:0] exp);
        send(CMD_READ, b, a, m, 32'h0);
        repeat (12) begin
            #1;
            if (rd_valid_o === 1'b1) break;
            @(posedge core_clk_i);
        end
        chk({31'h0, rd_valid_o}, 32'h1);
        chk(rd_data_o, exp);
        @(posedge core_clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_rw;
        cmd(CMD_MRS);
        send(CMD_ACT, 1'b0, 9'h005, 4'h0, 32'h0);
        send(CMD_ACT_MW, 1'b1, 9'h007, 4'h0, 32'h0);
        send(CMD_WRITE, 1'b0, 9'h003, 4'h0, 32'h11223344);
        send(CMD_WRITE, 1'b0, 9'h004, 4'h6, 32'hA5A5A5A5);
        rd(1'b0, 9'h003, 4'h0, 32'h11223344);
        rd(1'b0, 9'h004, 4'h0, 32'hA50000A5);
        rd(1'b0, 9'h103, 4'h9, 32'hEE2233BB);
    endtask
    task automatic t_blk;
        send(CMD_BWRITE, 1'b1, 9'h008, 4'h0, 32'h00000005);
        rd(1'b1, 9'h00A, 4'h0, COLOR);
        rd(1'b1, 9'h009, 4'h0, 32'h0);
    endtask
    // Enable drops and wakes; the model counts bad wake patterns
    task automatic t_pwr;
        send(CMD_PRE, 1'b1, 9'h000, 4'h0, 32'h0);
        cmd(CMD_PRE_ALL);
        cmd(CMD_ACT);
        cmd(CMD_PDOWN);
        #1 chk({31'h0, cke_o}, 32'h0);
        @(posedge core_clk_i);
        cmd(CMD_NOP);
        @(posedge core_clk_i); // Queue drains so the entry is checked
        cmd(CMD_SUSPEND);
        cmd(CMD_WAKE);
        cmd(CMD_STOP);
        cmd(CMD_SMRS);
        cmd(CMD_PRE_ALL);
        cmd(CMD_SREF);
        cmd(CMD_NOP);
        cmd(CMD_NOP);
        cmd(CMD_AREF);
        chk({24'h0, dev_err_o}, 32'h0);
    endtask
    task automatic t_fifo;
        req_valid_i <= 1'b1;
        req_i <= '{CMD_NOP, 1'b0, 9'h000, 1'b0, 4'h0, 32'h0};
        repeat (10) @(posedge core_clk_i);
        req_valid_i <= 1'b0;
        #1 chk({31'h0, busy_o}, 32'h1);
        repeat (20) @(posedge core_clk_i);
        #1 chk({30'h0, busy_o, req_ready_o}, 32'h1);
    endtask
    initial begin
        repeat (10) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        t_rw;
        t_blk;
        t_pwr;
        t_fifo;
        close_out;
    end
    // Traffic takes about 120 cycles; this is far beyond it
    initial begin
        repeat (5000) @(posedge core_clk_i);
        failures++;
        close_out;
    end
endmodule
`default_nettype wire
